// >>> design/mtrl_core_side.sv
// other end: core access path and configuring software port
`timescale 1ns/1ps
`include "mtrl_regs.svh"
module mtrl_core_side
    import mtrl_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // user configuration writes
    input wire logic cfg_valid_in,
    input wire mtrl_sel_type cfg_sel_in,
    input wire logic [`MTRL_PAIR_IDX_W-1:0] cfg_index_in,
    input wire logic [63:0] cfg_data_in,
    output logic cfg_fault_out,
    // user lookups
    input wire logic look_valid_in,
    input wire logic [`MTRL_PA_WIDTH-1:0] look_addr_in,
    input wire logic [`MTRL_TYPE_W-1:0] look_fixed_type_in,
    output logic look_done_out,
    output logic [`MTRL_TYPE_W-1:0] look_type_out,
    // link
    mtrl_if.host link
);
    typedef struct packed {
        logic fault;
        logic done;
        logic [`MTRL_TYPE_W-1:0] mtype;
    } mtrl_host_state_type;

    mtrl_host_state_type state_reg;
    mtrl_host_state_type state_next;

    // ====================================================
    // software must keep ranges aligned and zero-init
    assign link.wr_valid = cfg_valid_in;
    assign link.wr_sel = cfg_sel_in;
    assign link.wr_index = cfg_index_in;
    assign link.wr_data = cfg_data_in;
    assign link.req_valid = look_valid_in;
    assign link.req_addr = look_addr_in;
    assign link.fixed_type = look_fixed_type_in;

    always_comb begin
        state_next = state_reg;
        state_next.fault = link.protection_fault;
        state_next.done = link.rsp_valid;
        if (link.rsp_valid) begin
            state_next.mtype = link.rsp_type;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cfg_fault_out = state_reg.fault;
    assign look_done_out = state_reg.done;
    assign look_type_out = state_reg.mtype;
endmodule

// >>> design/mtrl_if.sv
// link between the lookup and the core access path / software
`timescale 1ns/1ps
`include "mtrl_regs.svh"
interface mtrl_if;
    import mtrl_pkg::*;
    logic wr_valid;
    mtrl_sel_type wr_sel;
    logic [`MTRL_PAIR_IDX_W-1:0] wr_index;
    logic [63:0] wr_data;
    logic protection_fault;
    logic req_valid;
    logic [`MTRL_PA_WIDTH-1:0] req_addr;
    logic [`MTRL_TYPE_W-1:0] fixed_type;
    logic rsp_valid;
    logic [`MTRL_TYPE_W-1:0] rsp_type;
    modport device (
        input wr_valid, wr_sel, wr_index, wr_data, req_valid, req_addr, fixed_type,
        output protection_fault, rsp_valid, rsp_type
    );
    modport host (
        output wr_valid, wr_sel, wr_index, wr_data, req_valid, req_addr, fixed_type,
        input protection_fault, rsp_valid, rsp_type
    );
endinterface

// >>> design/mtrl_lookup.sv
// device end: range registers and memory type resolution
`timescale 1ns/1ps
`include "mtrl_regs.svh"
module mtrl_lookup
    import mtrl_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // link
    mtrl_if.device link
);
    // address width and pair count come from the header
    localparam int PA = `MTRL_PA_WIDTH;
    localparam int NP = `MTRL_PAIRS;
    localparam int PS = `MTRL_PAGE_SHIFT;
    localparam int TW = `MTRL_TYPE_W;
    // field width is the address width less the page shift, 24 here
    localparam int FW = PA - PS;
    localparam logic [63:0] DEF_LEGAL = 64'h0000_0000_0000_0CFF;
    // base: type and address field; mask: valid and mask field
    localparam logic [63:0] ADDR_BITS = ((64'h1 << PA) - 64'h1) & ~64'h0FFF;
    localparam logic [63:0] BASE_LEGAL = ADDR_BITS | 64'h0FF;
    localparam logic [63:0] MASK_LEGAL = ADDR_BITS | 64'h800;

    typedef struct packed {
        logic [NP-1:0][PA-PS-1:0] base_field;
        logic [NP-1:0][TW-1:0] base_type;
        logic [NP-1:0][PA-PS-1:0] mask_field;
        logic [NP-1:0] valid;
        logic global_on;
        logic fixed_on;
        logic [TW-1:0] def_type;
        logic fault;
        logic stg_valid;
        logic stg_low;
        logic stg_fixed_on;
        logic stg_global_on;
        logic [NP-1:0] stg_hit;
        logic [TW-1:0] stg_fixed_type;
        logic [TW-1:0] stg_def_type;
        logic [NP-1:0][TW-1:0] stg_types;
        logic rsp_valid;
        logic [TW-1:0] rsp_type;
    } mtrl_state_type;

    mtrl_state_type state_reg;
    mtrl_state_type state_next;

    // ====================================================
    // write legality
    logic def_bad;
    logic base_bad;
    logic mask_bad;

    // a refused write leaves every range register as it was and only sets the fault flag
    assign def_bad = (link.wr_data & ~DEF_LEGAL) != 64'h0;
    assign base_bad = (link.wr_data & ~BASE_LEGAL) != 64'h0;
    assign mask_bad = (link.wr_data & ~MASK_LEGAL) != 64'h0;

    // ====================================================
    // per-pair compare on the incoming page
    logic [FW-1:0] req_page;
    logic [NP-1:0][FW-1:0] masked_page;
    logic [NP-1:0][FW-1:0] masked_base;
    logic [NP-1:0] pair_hit;

    assign req_page = link.req_addr[PA-1:PS];

    for (genvar g = 0; g < NP; g++) begin : g_pair
        assign masked_page[g] = req_page & state_reg.mask_field[g];
        assign masked_base[g] = state_reg.base_field[g] & state_reg.mask_field[g];
        // masked compare, gated by valid
        assign pair_hit[g] = state_reg.valid[g] &&
            (masked_page[g] == masked_base[g]);
    end

    // ====================================================
    // per-pair type classes of the registered hits
    logic [NP-1:0] stg_is_uc;
    logic [NP-1:0] stg_is_wt;
    logic [NP-1:0] stg_is_wb;
    logic [NP-1:0] stg_is_wtwb;

    // only pairs that hit count towards the uncacheable verdict
    for (genvar g = 0; g < NP; g++) begin : g_class
        assign stg_is_uc[g] = state_reg.stg_hit[g] &&
            (state_reg.stg_types[g] == `MTRL_TYPE_UC);
        assign stg_is_wt[g] = (state_reg.stg_types[g] == `MTRL_TYPE_WT);
        assign stg_is_wb[g] = (state_reg.stg_types[g] == `MTRL_TYPE_WB);
        assign stg_is_wtwb[g] = stg_is_wt[g] || stg_is_wb[g];
    end

    // ====================================================
    // next state
    always_comb begin
        logic [TW-1:0] t;
        logic any_hit;
        logic any_uc;
        logic all_same;
        logic only_wtwb;
        logic [TW-1:0] first_t;
        state_next = state_reg;
        t = `MTRL_TYPE_UC;
        any_hit = 1'b0;
        any_uc = 1'b0;
        all_same = 1'b1;
        only_wtwb = 1'b1;
        first_t = '0;
        state_next.fault = 1'b0;
        // register writes
        if (link.wr_valid) begin
            case (link.wr_sel)
                MTRL_SEL_DEFAULT: begin
                    if (def_bad) begin
                        state_next.fault = 1'b1;
                    end else begin
                        state_next.def_type = link.wr_data[TW-1:0];
                        state_next.fixed_on = link.wr_data[`MTRL_FIXED_ON_BIT];
                        state_next.global_on = link.wr_data[`MTRL_GLOBAL_ON_BIT];
                    end
                end
                MTRL_SEL_BASE: begin
                    if (base_bad) begin
                        state_next.fault = 1'b1;
                    end else begin
                        state_next.base_type[link.wr_index] = link.wr_data[TW-1:0];
                        state_next.base_field[link.wr_index] = link.wr_data[PA-1:PS];
                    end
                end
                MTRL_SEL_MASK: begin
                    if (mask_bad) begin
                        state_next.fault = 1'b1;
                    end else begin
                        state_next.valid[link.wr_index] = link.wr_data[`MTRL_VALID_BIT];
                        state_next.mask_field[link.wr_index] = link.wr_data[PA-1:PS];
                    end
                end
                default: begin
                    state_next.fault = 1'b1;
                end
            endcase
        end
        // stage one: config snapshot travels with the request, so a
        // write taken on the same edge only reaches later lookups
        state_next.stg_valid = link.req_valid;
        state_next.stg_low = (link.req_addr[PA-1:`MTRL_LOW_MB_BITS] == '0);
        state_next.stg_fixed_on = state_reg.fixed_on;
        state_next.stg_global_on = state_reg.global_on;
        state_next.stg_fixed_type = link.fixed_type;
        state_next.stg_def_type = state_reg.def_type;
        state_next.stg_types = state_reg.base_type;
        state_next.stg_hit = pair_hit;
        // stage two: precedence
        for (int i = NP - 1; i >= 0; i--) begin
            if (state_reg.stg_hit[i]) begin
                first_t = state_reg.stg_types[i];
            end
        end
        any_hit = |state_reg.stg_hit;
        any_uc = |stg_is_uc;
        for (int i = 0; i < NP; i++) begin
            if (state_reg.stg_hit[i]) begin
                if (state_reg.stg_types[i] != first_t) begin
                    all_same = 1'b0;
                end
                if (!stg_is_wtwb[i]) begin
                    only_wtwb = 1'b0;
                end
            end
        end
        // precedence: enable, fixed low megabyte, variable pairs, default
        if (!state_reg.stg_global_on) begin
            t = `MTRL_TYPE_UC;
        end else if (state_reg.stg_low && state_reg.stg_fixed_on) begin
            t = state_reg.stg_fixed_type;
        end else if (!any_hit) begin
            t = state_reg.stg_def_type;
        end else if (any_uc) begin
            t = `MTRL_TYPE_UC;
        end else if (all_same) begin
            t = first_t;
        end else if (only_wtwb) begin
            t = `MTRL_TYPE_WT;
        end else begin
            t = first_t; // undefined overlap: lowest pair wins
        end
        state_next.rsp_valid = state_reg.stg_valid;
        if (state_reg.stg_valid) begin
            state_next.rsp_type = t;
        end
    end

    // ====================================================
    // state register
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            // other range bits are undefined after reset, so zero serves too
            state_reg <= '0; // valid flags and global enable clear
        end else begin
            state_reg <= state_next;
        end
    end

    // ====================================================
    // outputs straight from flip-flops
    assign link.protection_fault = state_reg.fault;
    assign link.rsp_valid = state_reg.rsp_valid;
    assign link.rsp_type = state_reg.rsp_type;
endmodule

// >>> design/mtrl_pkg.sv
// types for the memory type range lookup
package mtrl_pkg;
    typedef enum logic [1:0] {
        MTRL_SEL_DEFAULT = 2'b00,
        MTRL_SEL_BASE = 2'b01,
        MTRL_SEL_MASK = 2'b10
    } mtrl_sel_type;
endpackage

// >>> design/mtrl_regs.svh
// constants for the memory type range lookup
// What this block does
// - reserved bit writes raise protection fault
// - mask holes resolve to default type
// - 36-bit: 24-bit fields, twelve zero bits appended
// - 40-bit: mask field widens to 28 bits
// - software ranges at least 4K, 4K aligned
// - larger ranges power of two, aligned
// - global enable clear gives uncacheable always
// - low megabyte uses fixed type when enabled
// - single variable match returns its type
// - identical matching types return that type
// - any uncacheable match returns uncacheable
// - write-through with write-back gives write-through
// - other overlaps undefined, software avoids
// - no match returns default type
// - reset clears valid flags and global enable
// - software zeroes all range registers first
// - match when masked address equals masked base
// - mask bit 11 is pair valid flag
// - default bit 10 gates fixed ranges
// - default bit 11 enables all range logic
`ifndef MTRL_REGS_SVH
`define MTRL_REGS_SVH
`define MTRL_PA_WIDTH 36
`define MTRL_PAIRS 8
`define MTRL_PAIR_IDX_W 3
`define MTRL_PAGE_SHIFT 12
`define MTRL_TYPE_LSB 0
`define MTRL_TYPE_W 8
`define MTRL_VALID_BIT 11
`define MTRL_FIXED_ON_BIT 10
`define MTRL_GLOBAL_ON_BIT 11
`define MTRL_LOW_MB_BITS 20
`define MTRL_TYPE_UC 8'h00
`define MTRL_TYPE_WC 8'h01
`define MTRL_TYPE_WT 8'h04
`define MTRL_TYPE_WB 8'h06
`define MTRL_LATENCY 2
`endif

// >>> verif/mtrl_props.sv
// concurrent checks on the lookup link
`timescale 1ns/1ps
`include "mtrl_regs.svh"
module mtrl_props
    import mtrl_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // writes
    input wire logic wr_valid,
    input wire mtrl_sel_type wr_sel,
    input wire logic [`MTRL_PAIR_IDX_W-1:0] wr_index,
    input wire logic [63:0] wr_data,
    input wire logic protection_fault,
    // lookups
    input wire logic req_valid,
    input wire logic [`MTRL_PA_WIDTH-1:0] req_addr,
    input wire logic [`MTRL_TYPE_W-1:0] fixed_type,
    input wire logic rsp_valid,
    input wire logic [`MTRL_TYPE_W-1:0] rsp_type
);
    logic wr_bad;
    logic glob_reg;
    logic fix_reg;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    always_comb begin
        case (wr_sel)
            MTRL_SEL_DEFAULT: wr_bad = |(wr_data & ~64'h0000_0000_0000_0CFF);
            MTRL_SEL_BASE: wr_bad = |(wr_data & ~64'h0000_000F_FFFF_F0FF);
            MTRL_SEL_MASK: wr_bad = |(wr_data & ~64'h0000_000F_FFFF_F800);
            default: wr_bad = 1'b1;
        endcase
    end
    // =====================================
    // enables mirrored from accepted writes only
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            glob_reg <= 1'b0;
            fix_reg <= 1'b0;
        end else if (wr_valid && !wr_bad && wr_sel == MTRL_SEL_DEFAULT) begin
            glob_reg <= wr_data[11];
            fix_reg <= wr_data[10];
        end
    end
    sequence s_take;
        req_valid;
    endsequence
    sequence s_low_fixed;
        req_valid && glob_reg && fix_reg && req_addr < 36'h0_0010_0000;
    endsequence
    a_fixed_latency: assert property (s_take |-> ##2 rsp_valid)
        else $error("lookup answer late");
    a_no_stray_rsp: assert property (rsp_valid |-> $past(req_valid, 2))
        else $error("answer without request");
    a_type_held: assert property (!rsp_valid |-> $stable(rsp_type))
        else $error("type moved between answers");
    a_off_gives_uc: assert property (s_take ##0 !glob_reg |-> ##2 rsp_type == 8'h00)
        else $error("type not uncacheable while off");
    a_fixed_low_mb: assert property (s_low_fixed |-> ##2 rsp_type == $past(fixed_type, 2))
        else $error("low megabyte type wrong");
    a_reserved_fault: assert property (wr_valid && wr_bad |=> protection_fault)
        else $error("reserved write not refused");
    a_legal_no_fault: assert property (wr_valid && !wr_bad |=> !protection_fault)
        else $error("legal write refused");
    a_fault_has_cause: assert property (protection_fault |-> $past(wr_valid))
        else $error("fault without write");
endmodule

// >>> verif/test_mtrl.sv
// bench: core side and lookup joined by the link
`timescale 1ns/1ps
`include "mtrl_regs.svh"
module test_mtrl;
    import mtrl_pkg::*;
    logic clk, rst_b, cv, lv, cf, ld;
    mtrl_sel_type cs;
    logic [2:0] ci;
    logic [63:0] cd, dr, bm [16];
    logic [35:0] la;
    logic [7:0] lf, lt, ty [3];
    logic [31:0] r;
    int fail_count = 0;
    int total_checks = 0;
    int seed = 32'haefe3d7d;
    mtrl_if link();
    mtrl_lookup mtrl_lookup_inst (.clock_in(clk), .rst_b_in(rst_b), .link(link));
    mtrl_core_side mtrl_core_side_inst (.clock_in(clk), .rst_b_in(rst_b), .cfg_valid_in(cv),
        .cfg_sel_in(cs), .cfg_index_in(ci), .cfg_data_in(cd), .cfg_fault_out(cf),
        .look_valid_in(lv), .look_addr_in(la), .look_fixed_type_in(lf),
        .look_done_out(ld), .look_type_out(lt), .link(link));
    mtrl_props mtrl_props_inst (.clock_in(clk), .rst_b_in(rst_b), .wr_valid(link.wr_valid),
        .wr_sel(link.wr_sel), .wr_index(link.wr_index), .wr_data(link.wr_data),
        .protection_fault(link.protection_fault), .req_valid(link.req_valid),
        .req_addr(link.req_addr), .fixed_type(link.fixed_type), .rsp_valid(link.rsp_valid),
        .rsp_type(link.rsp_type));
    // =====================================
    // reference resolution; types kept to UC, WT, WB when pairs overlap
    function automatic logic [7:0] exp_type(logic [35:0] a, logic [7:0] f);
        logic [7:0] t;
        logic hit;
        logic [35:0] m;
        t = dr[7:0];
        hit = 1'b0;
        if (!dr[11]) return 8'h00;
        if (dr[10] && a < 36'h0_0010_0000) return f;
        for (int i = 0; i < 8; i++) begin
            m = {bm[8+i][35:12], 12'h000};
            if (bm[8+i][11] && (a & m) == (bm[i][35:0] & m)) begin
                if (!hit || bm[i][7:0] == 8'h00) t = bm[i][7:0];
                else if (t != bm[i][7:0] && t != 8'h00) t = 8'h04;
                hit = 1'b1;
            end
        end
        return t;
    endfunction
    task automatic chk(string n, logic [63:0] s, logic [63:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(mtrl_sel_type s, int i, logic [63:0] d, logic f);
        @(posedge clk);
        cv <= 1'b1;
        cs <= s;
        ci <= i[2:0];
        cd <= d;
        @(posedge clk);
        cv <= 1'b0;
        @(posedge clk);
        #1 chk("fault", {63'h0, cf}, {63'h0, f});
        if (!f && s == MTRL_SEL_DEFAULT) dr = d;
        else if (!f) bm[{s == MTRL_SEL_MASK, i[2:0]}] = d;
    endtask
    task automatic pair(int i, logic [35:0] b, logic [35:0] m, logic [7:0] t, logic v);
        wr(MTRL_SEL_BASE, i, {28'h0, b | 36'(t)}, 1'b0);
        wr(MTRL_SEL_MASK, i, {28'h0, m | 36'(v) << 11}, 1'b0);
    endtask
    task automatic look(logic [35:0] a, logic [7:0] f);
        logic [7:0] e;
        e = exp_type(a, f);
        @(posedge clk);
        lv <= 1'b1;
        la <= a;
        lf <= f;
        @(posedge clk);
        lv <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("done", {63'h0, ld}, 64'h1);
        chk("type", {56'h0, lt}, {56'h0, e});
        chk("wire type", {56'h0, link.rsp_type}, {56'h0, e});
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        dr = 64'h0;
        foreach (bm[k]) bm[k] = 64'h0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #(4 * 5000);
        fail_count++;
        stop_test();
    end
    // =====================================
    initial begin
        ty = '{8'h00, 8'h04, 8'h06};
        {rst_b, cv, lv, ci, cd, la, lf} <= '0;
        cs <= MTRL_SEL_DEFAULT;
        do_reset();
        pair(0, 36'h0, 36'hFFC000000, 8'h06, 1'b1);
        look(36'h2000000, 8'h00);
        wr(MTRL_SEL_DEFAULT, 0, 64'hD06, 1'b1);
        wr(MTRL_SEL_BASE, 0, 64'h100, 1'b1);
        wr(MTRL_SEL_MASK, 0, 64'h1000000800, 1'b1);
        wr(mtrl_sel_type'(2'b11), 0, 64'h0, 1'b1);
        look(36'h2000000, 8'h00);
        $display("test faults done");
        wr(MTRL_SEL_DEFAULT, 0, 64'hC04, 1'b0);
        pair(1, 36'h4000000, 36'hFFE000000, 8'h06, 1'b1);
        pair(3, 36'h4000000, 36'hFFFC00000, 8'h00, 1'b1);
        pair(5, 36'hA0000000, 36'hFFF800000, 8'h01, 1'b1);
        pair(6, 36'h1000000, 36'hFFF000000, 8'h04, 1'b1);
        pair(7, 36'h0, 36'hFFE000000, 8'h06, 1'b1);
        look(36'h3000000, 8'h00);
        look(36'hA0000800, 8'h00);
        look(36'h4100000, 8'h00);
        look(36'h1000000, 8'h00);
        look(36'h0800000, 8'h00);
        look(36'h7000000, 8'h00);
        look(36'h0080000, 8'h01);
        wr(MTRL_SEL_DEFAULT, 0, 64'h804, 1'b0);
        look(36'h0080000, 8'h01);
        pair(1, 36'h4000000, 36'hFFE000000, 8'h06, 1'b0);
        look(36'h5000000, 8'h00);
        do_reset();
        look(36'h3000000, 8'h00);
        $display("test corners done");
        repeat (4) begin
            for (int i = 0; i < 8; i++) begin
                r = $random(seed);
                pair(i, {12'h0, r[23:12], 12'h0}, {12'hFFF, r[11:0], 12'h0},
                    ty[r[25:24] % 3], r[26]);
            end
            wr(MTRL_SEL_DEFAULT, 0, {52'h0, 1'b1, r[30], 2'b0, ty[r[29:28] % 3]}, 1'b0);
            repeat (30) begin
                r = $random(seed);
                look({12'h0, r[31:8]}, r[7:0]);
            end
        end
        $display("test random done");
        stop_test();
    end
endmodule
